// ### shared/quad_phy_pkg.sv
// Purpose: Constants and types for the quad PHY global control register block
// Assumes: One 25 MHz clock, synchronous active-low reset, MDC sampled as data
// Notes:   Register word is 16 bits, reached over the serial management frame
// What this block does
// - Any link change or jabber sets flag
// - Reading the register clears flag and interrupt
// - Auto media bit set: port 1 self-selects
// - Auto clear: port 1 follows select bit
// - Select set means twisted pair, clear AUI
// - Heartbeat enable gates heartbeat on all ports
// - Bad-polarity status only valid with correction on
// - Idle level sets receive data without carrier
// - One holds data high, zero holds low
// - Default idle drive is low with link 1 strap high, high with strap low
// - Idle bit resets to inverse of strap
// - Mask set suppresses link/jabber interrupt
package quad_phy_pkg;

    // Port count and register location
    localparam int         NUM_PORTS     = 4;
    localparam logic [4:0] GCR_ADDR      = 5'h08;

    // Field positions inside the global control word
    localparam int         BIT_IRQ_FLAG  = 13;
    localparam int         BIT_AUTO      = 12;
    localparam int         BIT_TP_SEL    = 11;
    localparam int         BIT_HB        = 10;
    localparam int         BIT_POL       = 9;
    localparam int         BIT_MAC_HI    = 8;
    localparam int         BIT_MAC_LO    = 6;
    localparam int         BIT_IDLE      = 4;
    localparam int         BIT_MASK      = 1;

    // Values after reset of the plain control bits
    localparam logic       RST_FLAG      = 1'h0;
    localparam logic       RST_AUTO      = 1'h1;
    localparam logic       RST_TP_SEL    = 1'h1;
    localparam logic       RST_HB        = 1'h1;
    localparam logic       RST_POL       = 1'h1;
    localparam logic       RST_MASK      = 1'h0;

    // Management frame fields and bit counts
    localparam logic [1:0] OP_READ       = 2'h2;
    localparam logic [1:0] OP_WRITE      = 2'h1;
    localparam logic [3:0] HEAD_LAST     = 4'hC;
    localparam logic [3:0] TA_LAST       = 4'h1;
    localparam logic [3:0] DATA_LAST     = 4'hF;

    // Management frame states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HEAD = 4'h2,
        ST_TA   = 4'h4,
        ST_DATA = 4'h8
    } mgmt_state_t;

endpackage

// ### core/global_ctrl_regs.sv
// Purpose: Storage, strap capture and interrupt flag of the global control word
// Assumes: Strobes are one-cycle pulses from the management frame engine
// Notes:   Reserved bits ignore writes and read as zero
`timescale 1ns/1ps
module global_ctrl_regs (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // Management access
    input  wire logic        i_wr_stb,
    input  wire logic [15:0] i_wr_data,
    input  wire logic        i_rd_stb,
    output logic      [15:0] o_rd_data,
    // Port events and straps
    input  wire logic [quad_phy_pkg::NUM_PORTS-1:0] i_link_change,
    input  wire logic [quad_phy_pkg::NUM_PORTS-1:0] i_jabber,
    input  wire logic [3:1]  i_rxd_strap,
    input  wire logic        i_link1_strap,
    // Field values
    output logic             o_irq_flag,
    output logic             o_auto,
    output logic             o_tp_sel,
    output logic             o_hb,
    output logic             o_pol,
    output logic      [2:0]  o_mac,
    output logic             o_idle,
    output logic             o_mask
);
    import quad_phy_pkg::*;

    logic       flag_reg;   // Link/jabber status flag
    logic       flag_next;  // Its next value
    logic       auto_reg;   // Port 1 automatic media selection
    logic       tp_reg;     // Port 1 twisted-pair select
    logic       hb_reg;     // Heartbeat enable
    logic       pol_reg;    // Polarity correction enable
    logic [2:0] mac_reg;    // MAC protocol select
    logic       idle_reg;   // Receive idle level
    logic       mask_reg;   // Link/jabber interrupt mask
    wire        event_any;  // Any port saw an event this cycle

    // Events on any port
    assign event_any = (|i_link_change) | (|i_jabber);

    // Set wins over the read-clear in the same cycle
    assign flag_next = event_any ? 1'h1 : (i_rd_stb ? 1'h0 : flag_reg);

    // Register update; straps are caught while reset is held
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            flag_reg <= RST_FLAG;
            auto_reg <= RST_AUTO;
            tp_reg   <= RST_TP_SEL;
            hb_reg   <= RST_HB;
            pol_reg  <= RST_POL;
            mac_reg  <= i_rxd_strap;
            idle_reg <= ~i_link1_strap;
            mask_reg <= RST_MASK;
        end
        else
        begin
            flag_reg <= flag_next;
            // Reserved and status positions of the write word are dropped
            if (i_wr_stb)
            begin
                auto_reg <= i_wr_data[BIT_AUTO];
                tp_reg   <= i_wr_data[BIT_TP_SEL];
                hb_reg   <= i_wr_data[BIT_HB];
                pol_reg  <= i_wr_data[BIT_POL];
                mac_reg  <= i_wr_data[BIT_MAC_HI:BIT_MAC_LO];
                idle_reg <= i_wr_data[BIT_IDLE];
                mask_reg <= i_wr_data[BIT_MASK];
            end
        end
    end

    // Read word assembly, reserved bits zero
    always_comb
    begin
        o_rd_data                        = 16'h0000;
        o_rd_data[BIT_IRQ_FLAG]          = flag_reg;
        o_rd_data[BIT_AUTO]              = auto_reg;
        o_rd_data[BIT_TP_SEL]            = tp_reg;
        o_rd_data[BIT_HB]                = hb_reg;
        o_rd_data[BIT_POL]               = pol_reg;
        o_rd_data[BIT_MAC_HI:BIT_MAC_LO] = mac_reg;
        o_rd_data[BIT_IDLE]              = idle_reg;
        o_rd_data[BIT_MASK]              = mask_reg;
    end

    // Field outputs straight from flip-flops
    assign o_irq_flag = flag_reg;
    assign o_auto     = auto_reg;
    assign o_tp_sel   = tp_reg;
    assign o_hb       = hb_reg;
    assign o_pol      = pol_reg;
    assign o_mac      = mac_reg;
    assign o_idle     = idle_reg;
    assign o_mask     = mask_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // An event sets the flag on the next edge, even against a read
    flag_set_a: assert property (event_any |=> flag_reg)
        else $error("link/jabber flag not set after event");

    // A read without a new event leaves the flag clear
    rd_clear_a: assert property (i_rd_stb && !event_any |=> !flag_reg)
        else $error("link/jabber flag not cleared by read");

    // Writes never touch the flag
    flag_hold_a: assert property (!event_any && !i_rd_stb |=> $stable(flag_reg))
        else $error("link/jabber flag changed without cause");
endmodule

// ### core/quad_phy_global_control.sv
// Purpose: Global control register of a quad PHY behind the serial management port
// Assumes: MDC and MDIO are synchronous inputs, MDC well below half the clock rate
// Notes:   Only the global control address answers; other addresses read zero
`timescale 1ns/1ps
module quad_phy_global_control (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_NRST,
    // Serial management port
    input  wire logic        I_MDC,
    input  wire logic        I_MDIO,
    output logic             O_MDIO,
    output logic             O_MDIO_OE,
    input  wire logic [4:0]  I_PHY_ADDR,
    // Straps sampled during reset
    input  wire logic [3:1]  I_RXD_STRAP,
    input  wire logic        I_LINK1_STRAP,
    // Port status inputs
    input  wire logic [quad_phy_pkg::NUM_PORTS-1:0] I_LINK_CHANGE,
    input  wire logic [quad_phy_pkg::NUM_PORTS-1:0] I_JABBER,
    input  wire logic [quad_phy_pkg::NUM_PORTS-1:0] I_BAD_POLARITY,
    input  wire logic        I_PORT1_AUTO_TP,
    // Receive path
    input  wire logic [quad_phy_pkg::NUM_PORTS-1:0] I_RX_CRS,
    input  wire logic [quad_phy_pkg::NUM_PORTS-1:0] I_RX_DATA,
    output logic      [quad_phy_pkg::NUM_PORTS-1:0] O_RX_DATA,
    // Control outputs to the port logic
    output logic             O_LJ_IRQ,
    output logic             O_PORT1_TP_MODE,
    output logic             O_HEARTBEAT_EN,
    output logic             O_POL_CORRECT_EN,
    output logic      [quad_phy_pkg::NUM_PORTS-1:0] O_BAD_POL_STATUS,
    output logic      [2:0]  O_MAC_PROTOCOL
);
    import quad_phy_pkg::*;

    // Frame engine state
    mgmt_state_t state_reg;      // Current frame phase
    mgmt_state_t state_next;     // Next frame phase
    logic        mdc_q_reg;      // MDC one clock ago
    logic [3:0]  cnt_reg;        // Bit counter within a phase
    logic [3:0]  cnt_next;       // Its next value
    logic [11:0] head_reg;       // Header bits gathered so far
    logic        is_read_reg;    // Frame is a read to this PHY
    logic        is_write_reg;   // Frame is a write to this PHY
    logic        hit_reg;        // Frame targets the global register
    logic [15:0] tx_reg;         // Read data shift register
    logic [15:0] rx_reg;         // Write data shift register
    logic        oe_reg;         // MDIO drive enable
    logic        out_reg;        // MDIO drive value
    logic        wr_stb_reg;     // One-cycle register write
    logic        rd_stb_reg;     // One-cycle register read
    logic [15:0] wr_data_reg;    // Word to write

    // Register bank values
    logic [15:0] rd_word;        // Current register contents
    logic        irq_flag;       // Link/jabber flag
    logic        auto_sel;       // Automatic media selection
    logic        tp_sel;         // Forced twisted-pair select
    logic        hb_en;          // Heartbeat enable
    logic        pol_en;         // Polarity correction enable
    logic [2:0]  mac_sel;        // MAC protocol select
    logic        idle_lvl;       // Receive idle level
    logic        irq_mask;       // Interrupt mask

    // Output flip-flops
    logic        tp_mode_reg;    // Port 1 medium
    logic [NUM_PORTS-1:0] pol_stat_reg; // Qualified polarity status
    logic [NUM_PORTS-1:0] rx_out_reg;   // Receive data to the MACs

    // Decode wires
    wire         mdc_rise;       // MDC rising edge seen this clock
    wire  [12:0] head_cap;       // Complete header incl. current bit
    wire         head_done;      // Last header bit on this edge
    wire         head_ours;      // Start bit and address match
    wire         ta_done;        // Second turnaround bit on this edge
    wire         data_done;      // Last data bit on this edge

    // MDC edge detect; inputs are synchronous so no synchroniser
    assign mdc_rise  = I_MDC & ~mdc_q_reg;
    assign head_cap  = {head_reg, I_MDIO};
    assign head_done = (state_reg == ST_HEAD) && mdc_rise && (cnt_reg == HEAD_LAST);
    assign head_ours = head_cap[12] && (head_cap[9:5] == I_PHY_ADDR);
    assign ta_done   = (state_reg == ST_TA) && mdc_rise && (cnt_reg == TA_LAST);
    assign data_done = (state_reg == ST_DATA) && mdc_rise && (cnt_reg == DATA_LAST);

    // Next state and counter
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            // Preamble ones; a zero is the first start bit
            ST_IDLE:
            begin
                if (mdc_rise && !I_MDIO)
                begin
                    state_next = ST_HEAD;
                    cnt_next   = 4'h0;
                end
            end
            // Header (second start bit, opcode, addresses), two turnaround bits,
            // sixteen data bits: count MDC rises and move on after each last bit
            ST_HEAD, ST_TA, ST_DATA:
            begin
                if (mdc_rise)
                begin
                    cnt_next = cnt_reg + 4'h1;
                end
                if (head_done || ta_done || data_done)
                begin
                    cnt_next = 4'h0;
                end
                if (head_done)
                begin
                    state_next = ST_TA;
                end
                else if (ta_done)
                begin
                    state_next = ST_DATA;
                end
                else if (data_done)
                begin
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
                cnt_next   = 4'h0;
            end
        endcase
    end

    // Frame state, counter and edge history
    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 4'h0;
            mdc_q_reg <= 1'h0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            mdc_q_reg <= I_MDC;
        end
    end

    // Header capture and frame classification
    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            head_reg     <= 12'h000;
            is_read_reg  <= 1'h0;
            is_write_reg <= 1'h0;
            hit_reg      <= 1'h0;
        end
        else if ((state_reg == ST_HEAD) && mdc_rise)
        begin
            head_reg <= head_cap[11:0];
            if (head_done)
            begin
                is_read_reg  <= head_ours && (head_cap[11:10] == OP_READ);
                is_write_reg <= head_ours && (head_cap[11:10] == OP_WRITE);
                hit_reg      <= head_cap[4:0] == GCR_ADDR;
            end
        end
    end

    // MDIO drive: release, drive zero in second turnaround, then data
    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            oe_reg  <= 1'h0;
            out_reg <= 1'h0;
            tx_reg  <= 16'h0000;
        end
        else if (mdc_rise && is_read_reg)
        begin
            if ((state_reg == ST_TA) && !ta_done)
            begin
                oe_reg  <= 1'h1;
                out_reg <= 1'h0;
            end
            else if (ta_done)
            begin
                // Snapshot taken one clock before the read strobe clears the flag
                tx_reg  <= hit_reg ? rd_word : 16'h0000;
                out_reg <= hit_reg ? rd_word[15] : 1'h0;
            end
            else if (state_reg == ST_DATA)
            begin
                tx_reg  <= {tx_reg[14:0], 1'h0};
                out_reg <= tx_reg[14];
                if (data_done)
                begin
                    oe_reg <= 1'h0;
                end
            end
        end
    end

    // Write data shift and one-cycle access strobes
    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            rx_reg      <= 16'h0000;
            wr_stb_reg  <= 1'h0;
            rd_stb_reg  <= 1'h0;
            wr_data_reg <= 16'h0000;
        end
        else
        begin
            wr_stb_reg <= data_done && is_write_reg && hit_reg;
            rd_stb_reg <= ta_done && is_read_reg && hit_reg;
            if ((state_reg == ST_DATA) && mdc_rise)
            begin
                rx_reg <= {rx_reg[14:0], I_MDIO};
            end
            // Reserved bits of the word are expected to be zero
            if (data_done)
            begin
                wr_data_reg <= {rx_reg[14:0], I_MDIO};
            end
        end
    end

    // Register bank
    global_ctrl_regs global_ctrl_regs_inst (
        .i_clk         (I_CLK),
        .i_nrst        (I_NRST),
        .i_wr_stb      (wr_stb_reg),
        .i_wr_data     (wr_data_reg),
        .i_rd_stb      (rd_stb_reg),
        .o_rd_data     (rd_word),
        .i_link_change (I_LINK_CHANGE),
        .i_jabber      (I_JABBER),
        .i_rxd_strap   (I_RXD_STRAP),
        .i_link1_strap (I_LINK1_STRAP),
        .o_irq_flag    (irq_flag),
        .o_auto        (auto_sel),
        .o_tp_sel      (tp_sel),
        .o_hb          (hb_en),
        .o_pol         (pol_en),
        .o_mac         (mac_sel),
        .o_idle        (idle_lvl),
        .o_mask        (irq_mask)
    );

    // Port 1 medium and polarity status qualification
    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            tp_mode_reg  <= 1'h1;
            pol_stat_reg <= '0;
        end
        else
        begin
            // Automatic choice overrides the select bit
            tp_mode_reg  <= auto_sel ? I_PORT1_AUTO_TP : tp_sel;
            pol_stat_reg <= pol_en ? I_BAD_POLARITY : '0;
        end
    end

    // Receive data per port: idle level while carrier is absent
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : g_rx
            always_ff @(posedge I_CLK)
            begin
                if (!I_NRST)
                begin
                    rx_out_reg[p] <= 1'h0;
                end
                else
                begin
                    rx_out_reg[p] <= I_RX_CRS[p] ? I_RX_DATA[p] : idle_lvl;
                end
            end
        end
    endgenerate

    // Output drive
    assign O_MDIO           = out_reg;
    assign O_MDIO_OE        = oe_reg;
    assign O_LJ_IRQ         = irq_flag & ~irq_mask;
    assign O_PORT1_TP_MODE  = tp_mode_reg;
    assign O_HEARTBEAT_EN   = hb_en;
    assign O_POL_CORRECT_EN = pol_en;
    assign O_BAD_POL_STATUS = pol_stat_reg;
    assign O_MAC_PROTOCOL   = mac_sel;
    assign O_RX_DATA        = rx_out_reg;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);

    sequence write_done_s;
        data_done && is_write_reg && hit_reg;
    endsequence
    sequence in_reset_s;
        !I_NRST;
    endsequence

    auto_media_a: assert property (auto_sel |=> O_PORT1_TP_MODE == $past(I_PORT1_AUTO_TP))
        else $error("auto media choice not followed");
    forced_media_a: assert property (!auto_sel |=> O_PORT1_TP_MODE == $past(tp_sel))
        else $error("forced media not from select bit");
    heartbeat_write_a: assert property (write_done_s ##1 1 |=> O_HEARTBEAT_EN == $past(wr_data_reg[BIT_HB]))
        else $error("heartbeat enable not updated by write");
    pol_gate_a: assert property (!pol_en |=> O_BAD_POL_STATUS == '0)
        else $error("polarity status shown while correction off");
    mac_strap_a: assert property (@(posedge I_CLK) disable iff (1'b0)
        in_reset_s |=> O_MAC_PROTOCOL == $past(I_RXD_STRAP))
        else $error("protocol field not loaded from straps");
    idle_strap_a: assert property (@(posedge I_CLK) disable iff (1'b0)
        in_reset_s |=> idle_lvl == !$past(I_LINK1_STRAP))
        else $error("idle level not inverse of strap");
    rx_idle_a: assert property (!I_RX_CRS[0] |=> O_RX_DATA[0] == $past(idle_lvl))
        else $error("receive data not at idle level");
    irq_mask_a: assert property (irq_mask |-> !O_LJ_IRQ)
        else $error("interrupt raised while masked");
    // An event with the mask clear and no write pending raises the line next clock
    irq_raise_a: assert property (((|I_LINK_CHANGE) || (|I_JABBER)) && !irq_mask && !wr_stb_reg
        |=> O_LJ_IRQ)
        else $error("interrupt not raised on event");
    irq_withdraw_a: assert property (rd_stb_reg && !(|I_LINK_CHANGE) && !(|I_JABBER)
        |=> !O_LJ_IRQ)
        else $error("interrupt not withdrawn by read");
endmodule

// ### sim/mgmt_entity.sv
// Purpose: Management entity model that drives serial management frames
// Assumes: MDC half period of four system clocks, changes on falling edges
// Notes:   A released data line reads high through its pull-up
`timescale 1ns/1ps
module mgmt_entity (
    // Clock
    input  wire logic clk,
    // Device side of the data line
    input  wire logic o_mdio,
    input  wire logic o_mdio_oe,
    // Line levels seen by the device
    output logic      mdc,
    output logic      mdio
);
    import quad_phy_pkg::*;
    logic m_d;  // Our data bit
    logic m_oe; // Our drive enable
    // Wire level: device, then us, else pull-up
    assign mdio = o_mdio_oe ? o_mdio : (m_oe ? m_d : 1'h1);
    // Idle line at time zero
    initial
    begin
        mdc  = 1'h0;
        m_d  = 1'h1;
        m_oe = 1'h0;
    end
    // One MDC period; the line is sampled just before the rise
    task automatic one_bit(input logic d, input logic oe, output logic s);
        m_d  = d;
        m_oe = oe;
        repeat (4) @(negedge clk);
        s   = mdio;
        mdc = 1'h1;
        repeat (4) @(negedge clk);
        mdc = 1'h0;
    endtask
    // Preamble, header, turnaround, then sixteen data bits
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [15:0] hdr;
        logic        s;
        hdr = {2'h1, op, phy, ra, 2'h2};
        wd  = wd & 16'h1FD2; // Reserved positions always sent as zero
        repeat (2) one_bit(1'h1, 1'h1, s);
        for (int i = 15; i >= 0; i--) one_bit(hdr[i], !(op == OP_READ && i < 2), s);
        for (int i = 15; i >= 0; i--)
        begin
            one_bit(wd[i], op != OP_READ, s);
            rd[i] = s;
        end
        m_oe = 1'h0;
        // Released line rests one clock before the next frame drives it again
        @(negedge clk);
    endtask
endmodule

// ### sim/quad_phy_global_control_tb.sv
// Purpose: Self-checking bench for the global control register block
// Assumes: Inputs change on falling edges, reads scored through a queue
// Notes:   Configuration words are random under a fixed seed
`timescale 1ns/1ps
module quad_phy_global_control_tb;
    import quad_phy_pkg::*;
    logic        clk, nrst, mdc, mdio, o_mdio, o_oe, l1_strap, auto_tp;
    logic        irq, tp_mode, hb, pol;
    logic [3:1]  mac_strap;
    logic [3:0]  lchg, jab, badp, crs, rxd, rxo, bps;
    logic [2:0]  mac;
    logic [15:0] rd_word, w;
    logic [15:0] exp_q[$];
    int          miscompares, samples_checked;
    event        got;
    // Device under test
    quad_phy_global_control quad_phy_global_control_inst (.I_CLK(clk), .I_NRST(nrst),
        .I_MDC(mdc), .I_MDIO(mdio), .O_MDIO(o_mdio), .O_MDIO_OE(o_oe), .I_PHY_ADDR(5'h05),
        .I_RXD_STRAP(mac_strap), .I_LINK1_STRAP(l1_strap), .I_LINK_CHANGE(lchg),
        .I_JABBER(jab), .I_BAD_POLARITY(badp), .I_PORT1_AUTO_TP(auto_tp), .I_RX_CRS(crs),
        .I_RX_DATA(rxd), .O_RX_DATA(rxo), .O_LJ_IRQ(irq), .O_PORT1_TP_MODE(tp_mode),
        .O_HEARTBEAT_EN(hb), .O_POL_CORRECT_EN(pol), .O_BAD_POL_STATUS(bps),
        .O_MAC_PROTOCOL(mac));
    // Management entity on the far side
    mgmt_entity mgmt_entity_inst (.clk(clk), .o_mdio(o_mdio), .o_mdio_oe(o_oe),
        .mdc(mdc), .mdio(mdio));
    // 25 MHz clock
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        $display("miscompares %0d, samples_checked %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Read frame; the expected word is queued first
    task automatic rd(input logic [4:0] ra, input logic [15:0] e);
        logic [15:0] r;
        exp_q.push_back(e);
        mgmt_entity_inst.frame(OP_READ, 5'h05, ra, 16'h0000, r);
        rd_word = r;
        -> got;
    endtask
    // Write frame to the global word, then let the outputs settle
    task automatic wr(input logic [15:0] v);
        logic [15:0] r;
        mgmt_entity_inst.frame(OP_WRITE, 5'h05, GCR_ADDR, v, r);
        repeat (6) @(negedge clk);
    endtask
    // Control pins against a register word, flag assumed clear
    task automatic pins(input logic [15:0] v);
        logic [15:0] e;
        e = {1'h0, v[12] ? auto_tp : v[11], v[10], v[9], v[8:6], badp & {4{v[9]}},
             (crs & rxd) | (~crs & {4{v[4]}}), 1'h0};
        check({1'h0, tp_mode, hb, pol, mac, bps, rxo, irq}, e);
    endtask
    // Scoreboard: oldest note against each finished read
    always @(got) check(rd_word, exp_q.pop_front());
    // Watchdog
    initial
    begin
        repeat (40000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
    // Main sequence
    initial
    begin
        void'($urandom(24019));
        {nrst, lchg, jab, badp, crs, rxd, auto_tp} = 22'h0;
        mac_strap = 3'($urandom);
        l1_strap  = 1'($urandom);
        repeat (12) @(negedge clk);
        nrst = 1'h1;
        @(negedge clk);
        // Reset word and pins, then an unmapped address
        w = {7'h0F, mac_strap, 1'h0, ~l1_strap, 4'h0};
        pins(w);
        rd(GCR_ADDR, w);
        rd(5'h09, 16'h0000);
        // Another PHY's read floats high; writes elsewhere leave the word alone
        exp_q.push_back(16'hFFFF);
        mgmt_entity_inst.frame(OP_READ, 5'h06, GCR_ADDR, 16'h0000, rd_word);
        -> got;
        mgmt_entity_inst.frame(OP_WRITE, 5'h06, GCR_ADDR, 16'h0000, w);
        mgmt_entity_inst.frame(OP_WRITE, 5'h05, 5'h09, 16'h0000, w);
        w = {7'h0F, mac_strap, 1'h0, ~l1_strap, 4'h0};
        rd(GCR_ADDR, w);
        // Random configurations covering every media and idle combination
        for (int i = 0; i < 8; i++)
        begin
            w = 16'($urandom) & 16'h1FD2;
            w[12:11] = i[1:0];
            w[4] = i[2];
            wr(w);
            {auto_tp, badp, crs, rxd} = 13'($urandom);
            repeat (2) @(negedge clk);
            pins(w);
            rd(GCR_ADDR, w);
        end
        // Link and jabber events on each port, mask alternating
        for (int k = 0; k < 8; k++)
        begin
            w = 16'h1E00;
            w[1] = k[0];
            wr(w);
            if (k < 4) lchg = 4'h1 << k[1:0];
            else jab = 4'h1 << k[1:0];
            @(negedge clk);
            lchg = 4'h0;
            jab = 4'h0;
            repeat (2) @(negedge clk);
            check({15'h0, irq}, {15'h0, ~w[1]});
            rd(GCR_ADDR, w | 16'h2000);
            check({15'h0, irq}, 16'h0000);
            rd(GCR_ADDR, w);
        end
        // Let the scoreboard take the last read, then every note must be used
        @(negedge clk);
        check(16'(exp_q.size()), 16'h0000);
        report_and_stop();
    end
endmodule
